/* hw/tcos_source.v */
/*
 * Tandem connection overhead source: rewrites N1 of each container with
 * the error code, indication bits and multiframed alignment and trace, and
 * compensates B3, with an Avalon-MM slave for control, trace and status.
 * Assumes one byte per clock while clk_en is high, frame start marking the
 * first overhead byte, and all indication inputs on the same clock.
 */
`include "tcos_map.vh"

// Contract
// - Remote defect request sets N1 bit 8 in frame 73 within 20 ms.
// - N1 bits 7 and 8 form a 76-frame multiframe of 9.5 ms.
// - Remote error value is copied into N1 bit 5 every frame.
// - Outgoing defect request sets N1 bit 7 in frame 74 within 20 ms.
// - Outgoing error value is copied into N1 bit 6 every frame.
// - Frames 1 to 8 carry the sixteen-bit alignment pattern, two bits each.
// - Frames 9 to 72 carry the management trace, two bits each.
// - Unused bit 7 and 8 positions in frames 73 to 76 are zero.
// - Even parity of previous container versus current B3 gives violation count.
// - Server fail forces error code 1110 into N1 bits 1 to 4.
// - Counts 1 to 8 sent in binary; zero violations sent as 1001.
// - B3 is compensated from previous B3 and N1, in and out, and current B3.
module tcos_source (
   // Clock, reset, enable
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   // Adapted stream in
   input wire [7:0] adapted_data_in,
   input wire adapted_frame_start_in,
   input wire server_fail_in,
   // Indications from the sink side
   input wire remote_defect_request,
   input wire remote_error_value,
   input wire outgoing_defect_request,
   input wire outgoing_error_value,
   // Connection point out
   output reg [7:0] connection_data_out,
   output reg connection_frame_start_out,
   // Avalon-MM slave
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest
);

   // ========================================================================
   // Declarations
   reg insert_en;
   reg [127:0] trace_id_to_send;
   reg bus_ack;
   reg [11:0] byte_idx;
   reg [6:0] mf_frame;
   reg [7:0] bip_acc;
   reg [7:0] prev_bip;
   reg [3:0] iec_hold;
   reg [7:0] prev_b3_in;
   reg [7:0] prev_b3_out;
   reg [7:0] prev_n1_in;
   reg [7:0] prev_n1_out;
   reg [1:0] mf_bits;
   reg [7:0] next_out;
   reg [31:0] next_rdata;
   wire [3:0] iec_code;
   wire [11:0] cur_idx;
   wire [6:0] cur_mf;
   wire [6:0] mf_step;
   wire [6:0] trace_pos;
   wire [6:0] fas_pos;
   wire [7:0] n1_new;
   wire [7:0] b3_comp;
   wire bus_req;
   wire [7:0] bus_ofs;
   wire [15:0] align_pat;
   wire [3:0] fas_hi;
   wire [3:0] fas_lo;

   // ========================================================================
   // Avalon slave: one wait state, readdata latched on the first edge;
   // waitrequest stays high while clk_en is low, so no access is dropped
   assign bus_req = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~(bus_ack & clk_en);
   assign bus_ofs = {2'b00, avs_address, 2'b00};

   // Read mux; unmapped words read as zero
   always @* begin
      case (bus_ofs)
         `TCOS_OFS_CTRL: next_rdata = {31'h0, insert_en};
         `TCOS_OFS_STATUS: next_rdata = {17'h0, mf_frame, 4'h0, iec_hold};
         `TCOS_OFS_TRACE0: next_rdata = trace_id_to_send[127:96];
         `TCOS_OFS_TRACE1: next_rdata = trace_id_to_send[95:64];
         `TCOS_OFS_TRACE2: next_rdata = trace_id_to_send[63:32];
         `TCOS_OFS_TRACE3: next_rdata = trace_id_to_send[31:0];
         default: next_rdata = 32'h0;
      endcase
   end

   // Bus registers; clk_en low freezes the bus along with the stream
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack <= 1'b0;
         avs_readdata <= 32'h0;
         insert_en <= `TCOS_CTRL_RESET;
         trace_id_to_send <= `TCOS_TRACE_RESET;
      end else if (clk_en) begin
         bus_ack <= bus_req & ~bus_ack;
         if (avs_read & ~bus_ack) begin
            avs_readdata <= next_rdata;
         end
         if (avs_write & bus_ack) begin
            case (bus_ofs)
               `TCOS_OFS_CTRL: insert_en <= avs_writedata[`TCOS_CTRL_INSERT_BIT];
               `TCOS_OFS_TRACE0: trace_id_to_send[127:96] <= avs_writedata;
               `TCOS_OFS_TRACE1: trace_id_to_send[95:64] <= avs_writedata;
               `TCOS_OFS_TRACE2: trace_id_to_send[63:32] <= avs_writedata;
               `TCOS_OFS_TRACE3: trace_id_to_send[31:0] <= avs_writedata;
               default: ;
            endcase
         end
      end
   end

   // ========================================================================
   // Position within container and multiframe for the current byte
   assign cur_idx = adapted_frame_start_in ? 12'h000 : byte_idx;
   assign mf_step = (mf_frame == `TCOS_MF_LEN) ? 7'h01 : (mf_frame + 7'h01);
   assign cur_mf = adapted_frame_start_in ? mf_step : mf_frame;
   assign trace_pos = (cur_mf - `TCOS_MF_TRACE_FIRST) << 1;
   assign fas_pos = (cur_mf - 7'h01) << 1;
   // Alignment pattern as a net so single bits can be picked out
   assign align_pat = `TCOS_MF_ALIGN;
   assign fas_hi = 4'hF - fas_pos[3:0];
   assign fas_lo = 4'hE - fas_pos[3:0];

   // Bits 7 and 8 by multiframe slot
   always @* begin
      if (cur_mf <= `TCOS_MF_FAS_LAST) begin
         mf_bits = {align_pat[fas_hi], align_pat[fas_lo]};
      end else if (cur_mf <= `TCOS_MF_TRACE_LAST) begin
         mf_bits = {trace_id_to_send[7'd127 - trace_pos],
                    trace_id_to_send[7'd126 - trace_pos]};
      end else if (cur_mf == `TCOS_MF_RDI_FRAME) begin
         mf_bits = {1'b0, remote_defect_request};
      end else if (cur_mf == `TCOS_MF_ODI_FRAME) begin
         mf_bits = {outgoing_defect_request, 1'b0};
      end else begin
         mf_bits = 2'b00;
      end
   end

   // N1 bit 1 is the MSB of the byte
   assign n1_new = {iec_hold, remote_error_value, outgoing_error_value, mf_bits};
   assign b3_comp = prev_b3_in ^ prev_b3_out ^ prev_n1_in ^ prev_n1_out
                    ^ adapted_data_in;

   // ========================================================================
   // Error code from parity of previous container against received B3
   tcos_iec_enc u_iec (
      .computed_bip(prev_bip),
      .received_b3(adapted_data_in),
      .server_fail(server_fail_in),
      .iec_code(iec_code)
   );

   // Output byte selection; with insertion off N1 passes and B3 keeps
   // the offset carried from the previous B3, so toggling needs no special case
   always @* begin
      if (cur_idx == `TCOS_B3_INDEX) begin
         next_out = b3_comp;
      end else if (cur_idx == `TCOS_N1_INDEX && insert_en) begin
         next_out = n1_new;
      end else begin
         next_out = adapted_data_in;
      end
   end

   // ========================================================================
   // Stream state; multiframe starts at slot 76 so the first frame is 1
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         byte_idx <= 12'h000;
         mf_frame <= `TCOS_MF_LEN;
         bip_acc <= 8'h00;
         prev_bip <= 8'h00;
         iec_hold <= `TCOS_IEC_ZERO;
         prev_b3_in <= 8'h00;
         prev_b3_out <= 8'h00;
         prev_n1_in <= 8'h00;
         prev_n1_out <= 8'h00;
         connection_data_out <= 8'h00;
         connection_frame_start_out <= 1'b0;
      end else if (clk_en) begin
         connection_data_out <= next_out;
         connection_frame_start_out <= adapted_frame_start_in;
         mf_frame <= cur_mf;
         // Saturate so a missing frame start never wraps onto B3 or N1
         if (cur_idx != `TCOS_FRAME_BYTES) begin
            byte_idx <= cur_idx + 12'h001;
         end
         // Parity covers every received byte, B3 included
         if (adapted_frame_start_in) begin
            prev_bip <= bip_acc;
            bip_acc <= adapted_data_in;
         end else begin
            bip_acc <= bip_acc ^ adapted_data_in;
         end
         if (cur_idx == `TCOS_B3_INDEX) begin
            iec_hold <= iec_code;
            prev_b3_in <= adapted_data_in;
            prev_b3_out <= b3_comp;
         end
         if (cur_idx == `TCOS_N1_INDEX) begin
            prev_n1_in <= adapted_data_in;
            prev_n1_out <= next_out;
         end
      end
   end

endmodule

/* hw/tcos_map.vh */
/*
 * Register offsets, field positions, reset values and timing figures for
 * the tandem connection overhead source.
 * Assumes it is included by its bare name in plain Verilog-2005 files.
 */
`ifndef TCOS_MAP_VH
`define TCOS_MAP_VH

// ==========================================================================
// Register byte offsets (Avalon word address = offset / 4)
`define TCOS_OFS_CTRL 8'h00
`define TCOS_OFS_STATUS 8'h04
`define TCOS_OFS_TRACE0 8'h10
`define TCOS_OFS_TRACE1 8'h14
`define TCOS_OFS_TRACE2 8'h18
`define TCOS_OFS_TRACE3 8'h1C

// ==========================================================================
// Control fields and reset values
`define TCOS_CTRL_INSERT_BIT 0
`define TCOS_CTRL_RESET 1'h1
`define TCOS_TRACE_RESET 128'h0

// ==========================================================================
// Status fields
`define TCOS_STAT_IEC_LSB 0
`define TCOS_STAT_MF_LSB 8

// ==========================================================================
// Container geometry: 9 rows of 261 bytes, path overhead in column 0
`define TCOS_ROW_BYTES 12'd261
`define TCOS_FRAME_BYTES 12'd2349
`define TCOS_B3_INDEX 12'd261
`define TCOS_N1_INDEX 12'd2088

// ==========================================================================
// Multiframe on N1 bits 7 and 8
`define TCOS_MF_LEN 7'd76
`define TCOS_MF_FAS_LAST 7'd8
`define TCOS_MF_TRACE_FIRST 7'd9
`define TCOS_MF_TRACE_LAST 7'd72
`define TCOS_MF_RDI_FRAME 7'd73
`define TCOS_MF_ODI_FRAME 7'd74
`define TCOS_MF_ALIGN 16'hFFFE
`define TCOS_MF_DURATION_US 9500

// ==========================================================================
// Error code values
`define TCOS_IEC_SERVER_FAIL 4'hE
`define TCOS_IEC_ZERO 4'h9

// ==========================================================================
// Response time for indication bits; one multiframe is always below it
`define TCOS_RESP_LIMIT_US 20000
`define TCOS_CLK_MHZ 125
`define TCOS_RESP_LIMIT_CYC (`TCOS_RESP_LIMIT_US * `TCOS_CLK_MHZ)

`endif

/* hw/tcos_iec_enc.v */
/*
 * Incoming error code encoder: counts mismatching bits between the
 * parity of the previous container and the received B3, and encodes the
 * count as a four-bit code.
 * Assumes the caller registers the result; purely combinational.
 */
`include "tcos_map.vh"

module tcos_iec_enc (
   // Parity inputs
   input wire [7:0] computed_bip,
   input wire [7:0] received_b3,
   input wire server_fail,
   // Encoded result
   output reg [3:0] iec_code
);

   // ========================================================================
   // Mismatch count
   wire [7:0] diff;
   wire [3:0] part [0:8];
   assign diff = computed_bip ^ received_b3;
   assign part[0] = 4'h0;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_cnt
         assign part[g + 1] = part[g] + {3'h0, diff[g]};
      end
   endgenerate

   // ========================================================================
   // Code selection; zero never goes out as all zeros
   always @* begin
      if (server_fail) begin
         iec_code = `TCOS_IEC_SERVER_FAIL;
      end else if (part[8] == 4'h0) begin
         iec_code = `TCOS_IEC_ZERO;
      end else begin
         iec_code = part[8];
      end
   end

endmodule

/* tb/tcos_source_monitor.sv */
/* Checker for the overhead source: pass-through, error code and N1 slots.
   Assumes the bind below; sees only the top module's ports. */
module tcos_source_monitor (
   // Clock, reset, enable
   input logic clk,
   input logic rst_n,
   input logic clk_en,
   // Stream and indications
   input logic [7:0] adapted_data_in,
   input logic adapted_frame_start_in,
   input logic server_fail_in,
   input logic remote_defect_request,
   input logic remote_error_value,
   input logic outgoing_defect_request,
   input logic outgoing_error_value,
   input logic [7:0] connection_data_out,
   input logic connection_frame_start_out,
   // Register bus
   input logic [3:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   input logic [31:0] avs_readdata,
   input logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] cnt, oidx;
   logic [6:0] mf;
   logic ce_q, sf_q, ins;
   wire [11:0] cur = adapted_frame_start_in ? 12'h000 : cnt;
   wire [6:0] nmf = (mf == 7'h4C) ? 7'h01 : mf + 7'h01;
   wire n1 = ce_q && oidx == 12'h828 && ins;
   // ==========
   // Byte index, multiframe slot and insert state, tracked from the ports
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 12'h92D;
         oidx <= 12'h92D;
         mf <= 7'h4C;
         ce_q <= 1'b0;
         sf_q <= 1'b0;
         ins <= 1'b1;
      end else begin
         ce_q <= clk_en;
         if (clk_en) begin
            cnt <= (cur == 12'h92D) ? cur : cur + 12'h001; // Saturates without a start
            oidx <= cur;
            if (adapted_frame_start_in)
               mf <= nmf;
            if (cur == 12'h105)
               sf_q <= server_fail_in;
            if (avs_write && !avs_waitrequest && avs_address == 4'h0)
               ins <= avs_writedata[0];
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_byte_pass: assert property (ce_q && oidx != 12'h105 && oidx != 12'h828 |->
      connection_data_out == $past(adapted_data_in)) else $error("byte altered");
   a_start_pass: assert property (ce_q |->
      connection_frame_start_out == $past(adapted_frame_start_in)) else $error("start lost");
   a_iec_nonzero: assert property (n1 |-> connection_data_out[7:4] != 4'h0)
      else $error("zero error code");
   a_fail_code: assert property (n1 && sf_q |-> connection_data_out[7:4] == 4'hE)
      else $error("fail code missing");
   a_err_copy: assert property (n1 |-> connection_data_out[3:2] ==
      {$past(remote_error_value), $past(outgoing_error_value)}) else $error("error bits");
   a_align_bits: assert property (n1 && mf <= 7'h08 |->
      connection_data_out[1:0] == ((mf == 7'h08) ? 2'b10 : 2'b11)) else $error("align");
   a_rdi_slot: assert property (n1 && mf == 7'h49 |->
      connection_data_out[1:0] == {1'b0, $past(remote_defect_request)}) else $error("rdi");
   a_odi_slot: assert property (n1 && mf == 7'h4A |->
      connection_data_out[1:0] == {$past(outgoing_defect_request), 1'b0}) else $error("odi");
   a_spare_zero: assert property (n1 && mf > 7'h4A |-> connection_data_out[1:0] == 2'b00)
      else $error("spare bits");
   c_fail: cover property (n1 && sf_q);
   c_off: cover property (ce_q && oidx == 12'h828 && !ins);
   c_fas_end: cover property (n1 && mf == 7'h08);
   c_rdi_set: cover property (n1 && mf == 7'h49 && $past(remote_defect_request));
endmodule
bind tcos_source tcos_source_monitor mon (.*);

/* tb/tcos_stream_model.sv */
/* Upstream model: one byte per enabled cycle, 2349-byte containers (300 bytes
   while short_fr is high, to move the multiframe on quickly), B3 set
   to the previous container's parity xored with err_mask.
   Assumes a free clock and an asynchronous active-low reset. */
module tcos_stream_model (
   // Clock and reset
   input logic clk,
   input logic rst_n,
   // Parity corruption
   input logic [7:0] err_mask,
   // Container length select
   input logic short_fr,
   // Stream out
   output logic clk_en,
   output logic [7:0] adapted_data_in,
   output logic adapted_frame_start_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] ph;
   logic [11:0] idx;
   logic [7:0] fr, par_c, par_p;
   wire [11:0] last = short_fr ? 12'h12B : 12'h92C;
   wire [11:0] nidx = (idx >= last) ? 12'h000 : idx + 12'h001;
   // A gap every sixteen cycles keeps the enable path busy
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph <= 4'h0;
         idx <= 12'h000;
         fr <= 8'h00;
         par_c <= 8'h00;
         par_p <= 8'h00;
         clk_en <= 1'b0;
         adapted_data_in <= 8'h00;
         adapted_frame_start_in <= 1'b1;
      end else begin
         ph <= ph + 4'h1;
         clk_en <= ph != 4'hF;
         if (clk_en) begin
            idx <= nidx;
            par_c <= ((idx == 12'h000) ? 8'h00 : par_c) ^ adapted_data_in;
            if (idx == 12'h000)
               par_p <= par_c;
            if (nidx == 12'h000)
               fr <= fr + 8'h01;
            adapted_frame_start_in <= nidx == 12'h000;
            adapted_data_in <= (nidx == 12'h105) ? par_p ^ err_mask : nidx[7:0] ^ fr;
         end
      end
   end
endmodule

/* tb/tcos_source_bench.sv */
/* Bench for the overhead source: register checks, then one full multiframe
   (short containers in its middle) with injected parity errors, indications
   and insert on and off.
   Assumes the stream model and the checker beside it. */
module tcos_source_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, sf = 1'b0, rdr = 1'b0, rev = 1'b0, odr = 1'b0;
   logic oev = 1'b0, rd = 1'b0, wr = 1'b0, ins = 1'b1, ce_d = 1'b0, ce, fs, fso, wtq;
   logic shrt = 1'b0;
   logic [1:0] mfb;
   logic [7:0] mask = 8'h00, din, dout, b3i, n1i, pb3i = 0, pb3o = 0, pn1i = 0, pn1o = 0;
   logic [3:0] adr = 4'h0, iec, last_iec;
   logic [31:0] wdat = 32'h0, rdat;
   logic [127:0] tr = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   logic [7:0] masks [10] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h7F,
      8'hFF, 8'h80};
   int ii, oi, fo = 0, fail_count = 0, checked = 0;
   tcos_stream_model up (.clk(clk), .rst_n(rst_n), .err_mask(mask), .short_fr(shrt), .clk_en(ce),
      .adapted_data_in(din), .adapted_frame_start_in(fs));
   tcos_source uut (.clk(clk), .rst_n(rst_n), .clk_en(ce), .adapted_data_in(din),
      .adapted_frame_start_in(fs), .server_fail_in(sf), .remote_defect_request(rdr),
      .remote_error_value(rev), .outgoing_defect_request(odr), .outgoing_error_value(oev),
      .connection_data_out(dout), .connection_frame_start_out(fso), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
      .avs_waitrequest(wtq));
   always #4 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      if (fail_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One Avalon transfer; the request holds until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int n;
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wtq !== 1'b0 && n < 40);
      if (n == 40) begin
         fail_count++;
         wrap_up();
      end
      r = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(nm, r, e);
   endtask
   // ==========
   // Stream watcher: B3 of every container and N1 of each 2349-byte container against the model
   always @(posedge clk) begin
      if (ce && rst_n) begin
         ii = fs ? 0 : ii + 1;
         if (ii == 261)
            b3i = din;
         if (ii == 2088)
            n1i = din;
      end
      if (ce_d) begin
         oi = fso ? 0 : oi + 1;
         if (oi == 0)
            fo++;
         if (oi == 261) begin
            chk("b3", dout, pb3i ^ pb3o ^ pn1i ^ pn1o ^ b3i);
            pb3i = b3i;
            pb3o = dout;
         end
         if (oi == 2088) begin
            iec = sf ? 4'hE : ($countones(mask) == 0 ? 4'h9 : 4'($countones(mask)));
            mfb = fo <= 8 ? {1'b1, fo != 8} : fo <= 72 ? tr[127 - 2 * (fo - 9) -: 2] :
               fo == 73 ? {1'b0, rdr} : fo == 74 ? {odr, 1'b0} : 2'b00;
            chk("n1", dout, ins ? {iec, rev, oev, mfb} : n1i);
            last_iec = iec;
            pn1i = n1i;
            pn1o = dout;
         end
      end
      ce_d = ce && rst_n;
   end
   // Main sequence; per-container settings change just after each start
   initial begin
      logic [31:0] r;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rchk("ctrl", 4'h0, 32'h1);
      rchk("trace0", 4'h4, 32'h0);
      for (int k = 0; k < 4; k++)
         bus(1'b1, 4'(4 + k), tr[127 - 32 * k -: 32], r);
      bus(1'b1, 4'h2, 32'hFFFF_FFFF, r);
      rchk("unmapped", 4'h2, 32'h0);
      rchk("trace1", 4'h5, tr[95:64]);
      // Frame 77 only waits for frame 76 to finish
      for (int f = 1; f <= 77; f++) begin
         for (int n = 0; fo < f; n++) begin
            @(posedge clk);
            if (n > 3000) begin
               fail_count++;
               wrap_up();
            end
         end
         mask <= masks[f % 10];
         sf <= f == 12 || f == 13;
         rev <= f[0];
         oev <= f[1];
         shrt <= f > 24 && f < 71;
         rdr <= f[2] ^ f[6];
         odr <= f[3];
         if (f == 16)
            rchk("status", 4'h1, {f[6:0], 4'h0, last_iec});
         if (f == 20 || f == 22) begin
            bus(1'b1, 4'h0, 32'(f == 22), r);
            ins = f == 22;
         end
      end
      wrap_up();
   end
endmodule
